// file: design/ctmw_top.v
// transceiver mode and wake control with wishbone registers
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ctmw_defines.vh"
module ctmw_top (
  input  wire        clock,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [2:0]  dev_mode_in,
  input  wire        tx_data_in,
  input  wire        bus_rx_in,
  input  wire        transceiver_supply,
  output reg         bus_tx_dominant,
  output reg         rx_data_out,
  output reg         interrupt_out_n,
  output reg         irq,
  output reg         restart_req
);
  localparam S_IDLE = 2'h0;
  localparam S_DOM1 = 2'h1;
  localparam S_REC  = 2'h2;
  localparam S_DOM2 = 2'h3;

  reg  [1:0]             trx_mode;
  reg  [2:0]             dev_mode_q;
  reg                    woken;
  reg                    wake_status_register;
  reg  [1:0]             irq_stat;
  reg  [1:0]             irq_mask;
  reg  [1:0]             wstate;
  reg                    bus_q;
  reg  [`CTMW_CNT_W-1:0] en_cnt;
  reg                    tx_armed;
  wire [`CTMW_CNT_W-1:0] phase_cnt;
  reg  [1:0]             next_mode;
  reg                    next_refused;
  reg  [1:0]             next_wstate;
  reg                    next_hit;

  function reg_write_hit;
    input       req;
    input       we;
    input       sel0;
    input [3:0] adr;
    input [3:0] offset;
    begin
      reg_write_hit = req & we & sel0 & (adr == offset);
    end
  endfunction

  // a phase at or past the ceiling is too slow to be part of a wake pattern
  function phase_expired;
    input [`CTMW_CNT_W-1:0] cnt;
    begin
      phase_expired = (cnt >= `CTMW_WAKE_MAX_CYC - 1);
    end
  endfunction

  function rearm_target;
    input [2:0] dev;
    begin
      case (dev)
        `CTMW_DEV_STOP,
        `CTMW_DEV_SLEEP,
        `CTMW_DEV_FAILSAFE: rearm_target = 1'b1;
        default:            rearm_target = 1'b0;
      endcase
    end
  endfunction

  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ctrl  = reg_write_hit(wb_req, wb_we_i, wb_sel_i[0], wb_adr_i, `CTMW_OFF_CTRL);
  wire wr_stat  = reg_write_hit(wb_req, wb_we_i, wb_sel_i[0], wb_adr_i, `CTMW_OFF_IRQ_STAT);
  wire wr_mask  = reg_write_hit(wb_req, wb_we_i, wb_sel_i[0], wb_adr_i, `CTMW_OFF_IRQ_MASK);
  wire fs_entry = (dev_mode_in == `CTMW_DEV_FAILSAFE) && (dev_mode_q != `CTMW_DEV_FAILSAFE);
  // only a change of device mode rearms; staying in Stop must not keep clearing a wake
  wire rearm_dev = (dev_mode_in != dev_mode_q) && rearm_target(dev_mode_in);
  wire bus_edge = bus_rx_in ^ bus_q;
  wire cnt_ok   = (phase_cnt >= `CTMW_WAKE_MIN_CYC - 1);

  function mode_allowed;
    input [1:0] mode;
    input [2:0] dev;
    begin
      case (mode)
        `CTMW_TRX_OFF:    mode_allowed = 1'b1;
        `CTMW_TRX_NORMAL,
        `CTMW_TRX_RXONLY: mode_allowed = (dev == `CTMW_DEV_NORMAL) || (dev == `CTMW_DEV_STOP);
        default:          mode_allowed = (dev != `CTMW_DEV_FAILSAFE);
      endcase
    end
  endfunction

  ctmw_phase_timer u_timer (
    .clock   (clock),
    .srst    (srst),
    .restart (bus_edge || wstate == S_IDLE),
    .count   (phase_cnt)
  );

  always @* begin
    next_mode    = trx_mode;
    next_refused = 1'b0;
    if (fs_entry) begin
      next_mode = `CTMW_TRX_WAKE;
    end else if (wr_ctrl) begin
      if (mode_allowed(wb_dat_i[1:0], dev_mode_in)) begin
        next_mode = wb_dat_i[1:0];
      end else begin
        next_refused = 1'b1;
      end
    end
  end

  // bus_rx_in high is recessive; a phase ends on an edge
  always @* begin
    next_wstate = wstate;
    next_hit    = 1'b0;
    case (wstate)
      S_IDLE: begin
        if (!bus_rx_in) begin
          next_wstate = S_DOM1;
        end
      end
      S_DOM1, S_REC: begin
        if (phase_expired(phase_cnt)) begin
          next_wstate = S_IDLE;
        end else if (bus_edge) begin
          next_wstate = cnt_ok ? wstate + 2'h1 : S_IDLE;
        end
      end
      S_DOM2: begin
        if (phase_expired(phase_cnt)) begin
          next_wstate = S_IDLE;
        end else if (bus_edge) begin
          next_wstate = S_IDLE;
          next_hit    = cnt_ok;
        end
      end
      default: next_wstate = S_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      trx_mode   <= `CTMW_TRX_OFF;
      dev_mode_q <= `CTMW_DEV_NORMAL;
      bus_q      <= 1'b1;
    end else begin
      trx_mode   <= next_mode;
      dev_mode_q <= dev_mode_in;
      bus_q      <= bus_rx_in;
    end
  end

  // detector only runs while wake capable and not yet woken
  always @(posedge clock) begin
    if (srst) begin
      wstate <= S_IDLE;
    end else if (trx_mode != `CTMW_TRX_WAKE || woken) begin
      wstate <= S_IDLE;
    end else begin
      wstate <= next_wstate;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      woken <= 1'b0;
    end else if (next_mode != trx_mode || rearm_dev) begin
      woken <= 1'b0;
    end else if (next_hit && trx_mode == `CTMW_TRX_WAKE && !woken) begin
      woken <= 1'b1;
    end
  end

  // delay restarts on every entry to normal, so a quick toggle cannot skip it
  always @(posedge clock) begin
    if (srst) begin
      en_cnt   <= {`CTMW_CNT_W{1'b0}};
      tx_armed <= 1'b0;
    end else if (next_mode != `CTMW_TRX_NORMAL || trx_mode != `CTMW_TRX_NORMAL) begin
      en_cnt   <= {`CTMW_CNT_W{1'b0}};
      tx_armed <= 1'b0;
    end else if (en_cnt < `CTMW_EN_CYC) begin
      en_cnt <= en_cnt + 1'b1;
    end else if (tx_data_in) begin
      tx_armed <= 1'b1;
    end
  end

  wire wake_hit = next_hit && trx_mode == `CTMW_TRX_WAKE && !woken && wstate == S_DOM2 &&
                  next_mode == trx_mode && !rearm_dev;
  wire wake_irq = wake_hit && (dev_mode_in == `CTMW_DEV_NORMAL || dev_mode_in == `CTMW_DEV_STOP);

  // set wins over a write-one clear in the same cycle
  always @(posedge clock) begin
    if (srst) begin
      wake_status_register <= 1'b0;
    end else if (wake_hit) begin
      wake_status_register <= 1'b1;
    end else if (wr_stat && wb_dat_i[8]) begin
      wake_status_register <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat[`CTMW_IRQ_WAKE_BIT] <= wake_irq |
        (irq_stat[`CTMW_IRQ_WAKE_BIT] & ~(wr_stat & wb_dat_i[`CTMW_IRQ_WAKE_BIT]));
      irq_stat[`CTMW_IRQ_REFUSED_BIT] <= next_refused |
        (irq_stat[`CTMW_IRQ_REFUSED_BIT] & ~(wr_stat & wb_dat_i[`CTMW_IRQ_REFUSED_BIT]));
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      irq_mask <= 2'h0;
    end else if (wr_mask) begin
      irq_mask <= wb_dat_i[1:0];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      restart_req <= 1'b0;
    end else begin
      restart_req <= wake_hit && (dev_mode_in == `CTMW_DEV_SLEEP);
    end
  end

  // outputs registered; one clock of latency is far below a 2 Mbaud bit
  always @(posedge clock) begin
    if (srst) begin
      bus_tx_dominant <= 1'b0;
    end else begin
      bus_tx_dominant <= (trx_mode == `CTMW_TRX_NORMAL) && tx_armed && !tx_data_in;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      rx_data_out <= 1'b1;
    end else if (trx_mode == `CTMW_TRX_NORMAL || trx_mode == `CTMW_TRX_RXONLY) begin
      rx_data_out <= bus_rx_in;
    end else if (trx_mode == `CTMW_TRX_WAKE) begin
      rx_data_out <= ~(woken | wake_hit);
    end else begin
      rx_data_out <= 1'b1;
    end
  end

  // a wake in device Normal or Stop pulls the pin at once; any status bit enabled in irq_mask also pulls it low
  always @(posedge clock) begin
    if (srst) begin
      interrupt_out_n <= 1'b1;
      irq             <= 1'b0;
    end else begin
      interrupt_out_n <= ~(|(irq_stat & irq_mask) | wake_irq);
      irq             <= |(irq_stat & irq_mask);
    end
  end

  // classic wishbone slave: ack one cycle after request, unmapped reads zero
  always @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `CTMW_OFF_CTRL:     wb_dat_o <= {30'h0000_0000, trx_mode};
          `CTMW_OFF_STATUS:   wb_dat_o <= {24'h00_0000, tx_armed, woken, dev_mode_q, wstate,
                                           transceiver_supply};
          `CTMW_OFF_IRQ_STAT: wb_dat_o <= {23'h00_0000, wake_status_register, 6'h00, irq_stat};
          `CTMW_OFF_IRQ_MASK: wb_dat_o <= {30'h0000_0000, irq_mask};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ctmw_top

// file: design/ctmw_defines.vh
// constants for the transceiver mode and wake control block
`ifndef CTMW_DEFINES_VH
`define CTMW_DEFINES_VH
`define CTMW_CLK_MHZ          125
`define CTMW_OFF_CTRL         4'h0
`define CTMW_OFF_STATUS       4'h4
`define CTMW_OFF_IRQ_STAT     4'h8
`define CTMW_OFF_IRQ_MASK     4'hC
`define CTMW_TRX_OFF          2'h0
`define CTMW_TRX_WAKE         2'h1
`define CTMW_TRX_NORMAL       2'h2
`define CTMW_TRX_RXONLY       2'h3
`define CTMW_DEV_NORMAL       3'h0
`define CTMW_DEV_STOP         3'h1
`define CTMW_DEV_SLEEP        3'h2
`define CTMW_DEV_RESTART      3'h3
`define CTMW_DEV_FAILSAFE     3'h4
`define CTMW_EN_TIME_NS       2000
`define CTMW_WAKE_MIN_NS      500
`define CTMW_WAKE_MAX_NS      1800
`define CTMW_EN_CYC           ((`CTMW_EN_TIME_NS * `CTMW_CLK_MHZ + 999) / 1000)
`define CTMW_WAKE_MIN_CYC     ((`CTMW_WAKE_MIN_NS * `CTMW_CLK_MHZ + 999) / 1000)
`define CTMW_WAKE_MAX_CYC     ((`CTMW_WAKE_MAX_NS * `CTMW_CLK_MHZ) / 1000)
`define CTMW_CNT_W            12
`define CTMW_IRQ_WAKE_BIT     0
`define CTMW_IRQ_REFUSED_BIT  1
`endif

// file: design/ctmw_phase_timer.v
// phase length counter for the wake pattern detector
`timescale 1ns/1ps
`include "ctmw_defines.vh"
module ctmw_phase_timer (
  input  wire                   clock,
  input  wire                   srst,
  input  wire                   restart,
  output reg  [`CTMW_CNT_W-1:0] count
);
  // saturates so a long idle never wraps into a valid phase
  always @(posedge clock) begin
    if (srst || restart) begin
      count <= {`CTMW_CNT_W{1'b0}};
    end else if (count != {`CTMW_CNT_W{1'b1}}) begin
      count <= count + 1'b1;
    end
  end
endmodule // ctmw_phase_timer

// file: verification/ctmw_bus_peer.sv
// far side model: other bus nodes wired with our driver
`timescale 1ns/1ps
module ctmw_bus_peer (
  input  wire bus_tx_dominant,
  input  wire peer_dominant,
  output wire bus_rx_in
);
  // wired bus: any dominant driver wins over recessive
  assign bus_rx_in = ~(bus_tx_dominant | peer_dominant);
endmodule // ctmw_bus_peer

// file: verification/ctmw_chk_sva.sv
// port assertions for the mode and wake block
`timescale 1ns/1ps
module ctmw_chk (
  input wire        clock,
  input wire        srst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [2:0]  dev_mode_in,
  input wire        tx_data_in,
  input wire        bus_rx_in,
  input wire        bus_tx_dominant,
  input wire        rx_data_out,
  input wire        interrupt_out_n,
  input wire        irq,
  input wire        restart_req
);
  reg [11:0] run;
  reg [11:0] last;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // saturating, so a stuck bus cannot wrap into a legal length
  always @(posedge clock) begin
    if (srst) run <= 12'h0;
    else if (!bus_rx_in) run <= (run == 12'hFFF) ? run : run + 12'h1;
    else run <= 12'h0;
    if (srst) last <= 12'h0;
    else if (bus_rx_in && run != 12'h0) last <= run;
  end
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_off_reset: assert property ($fell(srst) |-> rx_data_out && !bus_tx_dominant)
    else $error("not off after reset");
  a_tx_gate: assert property (bus_tx_dominant |-> !$past(tx_data_in)) else $error("dominant without tx");
  // a fall with irq still low can only come from a wake; status bits raise irq with it
  a_wake_rx: assert property ($fell(interrupt_out_n) && !irq |-> !rx_data_out) else $error("rx not low");
  a_wake_time: assert property ($fell(interrupt_out_n) && !irq |-> last >= 12'd63 && last <= 12'd225)
    else $error("wake phase length");
  a_int_mode: assert property ($fell(interrupt_out_n) && !irq |-> $past(dev_mode_in) <= 3'h1)
    else $error("interrupt in wrong mode");
  a_restart_sleep: assert property (restart_req |-> $past(dev_mode_in) == 3'h2 ##1 !restart_req)
    else $error("restart pulse");
  c_wake: cover property ($fell(interrupt_out_n));
  c_restart: cover property (restart_req);
  c_drive: cover property (bus_tx_dominant);
endmodule // ctmw_chk

// file: verification/ctmw_top_tb.sv
// testbench for the transceiver mode and wake block
`timescale 1ns/1ps
module ctmw_top_tb;
  reg         clock = 1'b0;
  reg         srst = 1'b1;
  reg         req = 1'b0;
  reg         w = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg  [31:0] dat = 32'h0;
  reg  [2:0]  dev = 3'h0;
  reg         tx = 1'b1;
  reg         sup = 1'b1;
  reg         pd = 1'b0;
  reg         saw_rs = 1'b0;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        ack, rxb, txd, rxo, int_n, irq, rs;
  integer     n_mismatch = 0;
  integer     check_count = 0;
  always #4 clock = ~clock;
  always @(posedge clock) if (rs) saw_rs <= 1'b1;
  ctmw_top i_dut (.clock(clock), .srst(srst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(w), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .dev_mode_in(dev), .tx_data_in(tx),
    .bus_rx_in(rxb), .transceiver_supply(sup), .bus_tx_dominant(txd), .rx_data_out(rxo),
    .interrupt_out_n(int_n), .irq(irq), .restart_req(rs));
  ctmw_bus_peer i_peer (.bus_tx_dominant(txd), .peer_dominant(pd), .bus_rx_in(rxb));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one classic cycle; request held until the rising edge that samples ack high
  task wb(input we_v, input [3:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clock);
      req <= 1'b1;
      w <= we_v;
      adr <= a;
      dat <= d;
      i = 0;
      @(posedge clock);
      while (ack !== 1'b1 && i < 20) begin
        i = i + 1;
        @(posedge clock);
      end
      if (i == 20) begin
        n_mismatch = n_mismatch + 1;
        wrap_up;
      end
      q = rdat;
      req <= 1'b0;
      w <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task look(input integer n);
    begin
      repeat (n) @(posedge clock);
      @(negedge clock);
    end
  endtask
  // dominant, recessive, dominant, each n cycles long
  task wake(input integer n);
    begin
      @(posedge clock);
      pd <= 1'b1;
      repeat (n) @(posedge clock);
      pd <= 1'b0;
      repeat (n) @(posedge clock);
      pd <= 1'b1;
      repeat (n) @(posedge clock);
      pd <= 1'b0;
      look(3);
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h2, 32'h0);
    dev <= 3'h2;
    wb(1'b1, 4'h0, 32'h2);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h2);
    wb(1'b1, 4'hC, 32'h3);
    look(1);
    chk(irq, 1'b1);
    wb(1'b1, 4'h8, 32'h2);
    dev <= 3'h0;
    look(1);
    chk(irq, 1'b0);
    wb(1'b1, 4'h0, 32'h3);
    rd(4'h0, 32'h3);
    sup <= 1'b0;
    pd <= 1'b1;
    tx <= 1'b0;
    look(3);
    chk({rxo, txd}, 2'b00);
    // tx left dominant across the mode change: the early bit must be swallowed
    wb(1'b1, 4'h0, 32'h2);
    sup <= 1'b1;
    pd <= 1'b0;
    look(300);
    chk(txd, 1'b0);
    @(posedge clock);
    tx <= 1'b1;
    repeat (3) @(posedge clock);
    tx <= 1'b0;
    look(3);
    chk({txd, rxo}, 2'b10);
    @(posedge clock);
    tx <= 1'b1;
    dev <= 3'h1;
    wb(1'b1, 4'h0, 32'h1);
    wake(100);
    chk({rxo, int_n, irq}, 3'b001);
    rd(4'h0, 32'h1);
    rd(4'h8, 32'h101);
    wb(1'b1, 4'h8, 32'h101);
    wb(1'b1, 4'h0, 32'h0);
    look(1);
    chk(rxo, 1'b1);
    wb(1'b1, 4'h0, 32'h1);
    wake(30);
    chk(rxo, 1'b1);
    @(posedge clock);
    dev <= 3'h2;
    wake(100);
    chk({rxo, saw_rs}, 2'b01);
    wb(1'b1, 4'h0, 32'h0);
    dev <= 3'h4;
    look(2);
    rd(4'h0, 32'h1);
    wrap_up;
  end
endmodule // ctmw_top_tb
bind ctmw_top ctmw_chk i_chk (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .dev_mode_in(dev_mode_in), .tx_data_in(tx_data_in), .bus_rx_in(bus_rx_in),
  .bus_tx_dominant(bus_tx_dominant), .rx_data_out(rx_data_out), .interrupt_out_n(interrupt_out_n),
  .irq(irq), .restart_req(restart_req));
